/* File: pkg/mps_cfg.svh */
// Constants of the parameter-page report and spindle start/stop handler.
// Assumes inclusion by the package, the top module and the testbench.
// Notes on behaviour
// [R1] Page control lives in byte 2 bits 7..6: current, changeable, default, saved.
// [R2] Changeable view shows alterable bits as one, all others as zero.
// [R3] Current values follow last good select, else saved, else defaults.
// [R4] Default view returns one page, or all pages for the all-pages code.
// [R5] Unsupported fields read zero; length byte marks the last supported field.
// [R6] Saved view returns one page or all pages filled with stored values.
// [R7] Saved values come from the last good format, or equal defaults.
// [R8] Current values change only when a select command succeeds.
// [R9] Saved values change only when a format command succeeds.
// [R10] A format ending without check status means saved values were stored.
// [R11] Initiator puts the wanted page code into command byte 2.
// [R12] Format page body is 22 bytes, none in the changeable view.
// [R13] Geometry page body is 16 bytes, none in the changeable view.
// [R14] All pages give 80 body bytes, or 42 in the changeable view.
// [R15] All-pages code is legal only in the sense command.
// [R16] Each page carries the same length byte in every all-pages report.
// [R17] Opcode 1BH starts or stops the spindle and moves the heads.
// [R18] Early status flag set: status once the spin is started.
// [R19] Early status flag clear: status after the spin completes.
// [R20] Start bit one spins up and seeks to track zero.
// [R21] Start bit zero spins down and parks the heads.
// [R22] Reserved page codes return nothing and give no error.
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH
`define MPS_OP_SENSE 8'h1A
`define MPS_OP_SELECT 8'h15
`define MPS_OP_FORMAT 8'h04
`define MPS_OP_SPIN 8'h1B
`define MPS_PC_ALL 6'h3F
`define MPS_PCF_CUR 2'b00
`define MPS_PCF_CHG 2'b01
`define MPS_PCF_DEF 2'b10
`define MPS_PCF_SAV 2'b11
`define MPS_PG_OPER 6'h00
`define MPS_PG_ERR 6'h01
`define MPS_PG_DISC 6'h02
`define MPS_PG_FMT 6'h03
`define MPS_PG_GEOM 6'h04
`define MPS_PG_VEND 6'h20
`define MPS_LEN_OPER 5'd2
`define MPS_LEN_ERR 5'd6
`define MPS_LEN_DISC 5'd10
`define MPS_LEN_FMT 5'd22
`define MPS_LEN_GEOM 5'd16
`define MPS_LEN_VEND 5'd24
`define MPS_BASE_OPER 7'd0
`define MPS_BASE_ERR 7'd2
`define MPS_BASE_DISC 7'd8
`define MPS_BASE_FMT 7'd18
`define MPS_BASE_GEOM 7'd40
`define MPS_BASE_VEND 7'd56
`define MPS_IMG_BYTES 80
`define MPS_ALL_CHG_BYTES 42
`endif

/* File: pkg/mps_pkg.sv */
// Types shared by the page report and start/stop handler.
// Assumes the constants header sits beside it.
`include "mps_cfg.svh"
package mps_pkg;
   typedef struct packed {
      logic [7:0] opc;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
      logic [7:0] b5;
   } mps_cdb_s;
   typedef struct packed {
      logic we;
      logic [5:0] page;
      logic [4:0] off;
      logic [7:0] data;
   } mps_selwr_s;
   typedef struct packed {
      logic valid;
      logic check;
   } mps_stat_s;
   typedef enum logic [2:0] {S_IDLE, S_CODE, S_LEN, S_BODY, S_SEL, S_FMT, S_SPIN, S_STAT} mps_state_e;
endpackage : mps_pkg

/* File: src/mps_top.sv */
// Command handler: parameter-page reports, select/format storage, spindle start/stop.
// Assumes command and select data come from initiator logic on clk_sys; spin_done_pin is asynchronous.
`timescale 1ns/1ps
`include "mps_cfg.svh"
module mps_top
   import mps_pkg::*;
#(
   parameter int IMG_BYTES = `MPS_IMG_BYTES,
   parameter logic [IMG_BYTES*8-1:0] DEF_IMAGE = '0,
   parameter logic [IMG_BYTES*8-1:0] CHG_MASK = '1
)(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire mps_cdb_s command_descriptor_block,
   output logic cmd_ready,
   input wire mps_selwr_s sel_wr,
   input wire logic sel_done,
   input wire logic sel_ok,
   input wire logic fmt_done,
   input wire logic fmt_ok,
   input wire logic save_capable,
   input wire logic spin_done_pin,
   output logic spin_start,
   output logic spin_up,
   output logic out_valid,
   output logic [7:0] out_data,
   input wire logic out_ready,
   output mps_stat_s stat
);
   localparam int IW = IMG_BYTES * 8;

   mps_state_e st_r, st_nxt;
   logic [2:0] slot_r, slot_nxt, nx_slot;
   logic [4:0] cnt_r, cnt_nxt;
   logic all_r, all_nxt, nx_hit;
   logic [1:0] page_control_field_r, pcf_nxt;
   logic chk_r, chk_nxt, bad_r, bad_nxt;
   logic [7:0] dat_r, dat_nxt;
   logic [IW-1:0] cur_r, cur_nxt, sav_r, sav_nxt, pend_r, pend_nxt;
   logic sstart_r, sstart_nxt, sup_r, sup_nxt;
   logic sd1_r, sd2_r, sd3_r;
   logic [3:0] hs;
   logic [6:0] bidx;
   logic [IW-1:0] saved_view;

   function automatic logic [4:0] pg_len(input logic [2:0] s, input logic [1:0] page_control_field);
      logic changeable_value_select;
      changeable_value_select = (page_control_field == `MPS_PCF_CHG);
      unique case (s)
         3'd0: pg_len = `MPS_LEN_OPER;
         3'd1: pg_len = `MPS_LEN_ERR;
         3'd2: pg_len = `MPS_LEN_DISC;
         3'd3: pg_len = changeable_value_select ? 5'd0 : `MPS_LEN_FMT;   // R12
         3'd4: pg_len = changeable_value_select ? 5'd0 : `MPS_LEN_GEOM;  // R13
         default: pg_len = `MPS_LEN_VEND;
      endcase
   endfunction : pg_len

   function automatic logic [6:0] pg_base(input logic [2:0] s);
      unique case (s)
         3'd0: pg_base = `MPS_BASE_OPER;
         3'd1: pg_base = `MPS_BASE_ERR;
         3'd2: pg_base = `MPS_BASE_DISC;
         3'd3: pg_base = `MPS_BASE_FMT;
         3'd4: pg_base = `MPS_BASE_GEOM;
         default: pg_base = `MPS_BASE_VEND;
      endcase
   endfunction : pg_base

   function automatic logic [5:0] pg_code(input logic [2:0] s);
      unique case (s)
         3'd0: pg_code = `MPS_PG_OPER;
         3'd1: pg_code = `MPS_PG_ERR;
         3'd2: pg_code = `MPS_PG_DISC;
         3'd3: pg_code = `MPS_PG_FMT;
         3'd4: pg_code = `MPS_PG_GEOM;
         default: pg_code = `MPS_PG_VEND;
      endcase
   endfunction : pg_code

   // Hit bit on top, slot below; reserved codes miss
   function automatic logic [3:0] hit_slot(input logic [5:0] c);
      case (c)
         `MPS_PG_OPER: hit_slot = 4'h8;
         `MPS_PG_ERR: hit_slot = 4'h9;
         `MPS_PG_DISC: hit_slot = 4'hA;
         `MPS_PG_FMT: hit_slot = 4'hB;
         `MPS_PG_GEOM: hit_slot = 4'hC;
         `MPS_PG_VEND: hit_slot = 4'hD;
         default: hit_slot = 4'h0;
      endcase
   endfunction : hit_slot

   // Without storage the saved view falls back to defaults
   assign saved_view = save_capable ? sav_r : DEF_IMAGE;  // R7

   // Next page with a non-empty body during an all-pages report
   always_comb
   begin
      nx_hit = 1'b0;
      nx_slot = slot_r;
      for (int i = 5; i >= 1; i--)
      begin
         if (3'(i) > slot_r && pg_len(3'(i), page_control_field_r) != 5'd0)
         begin
            nx_hit = all_r;  // R4 R6
            nx_slot = 3'(i);
         end
      end
   end

   always_comb
   begin
      st_nxt = st_r;
      slot_nxt = slot_r;
      cnt_nxt = cnt_r;
      all_nxt = all_r;
      pcf_nxt = page_control_field_r;
      chk_nxt = chk_r;
      bad_nxt = bad_r;
      cur_nxt = cur_r;
      sav_nxt = sav_r;
      pend_nxt = pend_r;
      sstart_nxt = 1'b0;
      sup_nxt = sup_r;
      hs = hit_slot(command_descriptor_block.b2[5:0]);  // R11
      unique case (st_r)
         S_IDLE:
            if (cmd_valid)
            begin
               chk_nxt = 1'b0;
               st_nxt = S_STAT;
               case (command_descriptor_block.opc)
                  `MPS_OP_SENSE:
                  begin
                     pcf_nxt = command_descriptor_block.b2[7:6];  // R1
                     all_nxt = command_descriptor_block.b2[5:0] == `MPS_PC_ALL;
                     cnt_nxt = 5'd0;
                     if (all_nxt)
                     begin
                        slot_nxt = 3'd0;
                        st_nxt = S_CODE;  // R4 R6 R14
                     end
                     else if (hs[3] && pg_len(hs[2:0], pcf_nxt) != 5'd0)
                     begin
                        slot_nxt = hs[2:0];
                        st_nxt = S_CODE;
                     end
                     // Reserved codes and empty changeable pages: status only  R22 R2
                  end
                  `MPS_OP_SELECT:
                  begin
                     pend_nxt = cur_r;
                     bad_nxt = 1'b0;
                     st_nxt = S_SEL;
                  end
                  `MPS_OP_FORMAT: st_nxt = S_FMT;
                  `MPS_OP_SPIN:
                  begin
                     sstart_nxt = 1'b1;  // R17
                     sup_nxt = command_descriptor_block.b4[0];  // R20 R21
                     st_nxt = command_descriptor_block.b1[0] ? S_STAT : S_SPIN;  // R18 R19
                  end
                  default: chk_nxt = 1'b1;
               endcase
            end
         S_CODE:
            if (out_ready)
               st_nxt = S_LEN;
         S_LEN, S_BODY:
            if (out_ready)
            begin
               if (st_r == S_LEN && pg_len(slot_r, page_control_field_r) != 5'd0)
               begin
                  st_nxt = S_BODY;
                  cnt_nxt = 5'd0;
               end
               else if (st_r == S_BODY && cnt_r != pg_len(slot_r, page_control_field_r) - 5'd1)
                  cnt_nxt = cnt_r + 5'd1;
               else if (nx_hit)
               begin
                  slot_nxt = nx_slot;
                  st_nxt = S_CODE;
               end
               else
                  st_nxt = S_STAT;
            end
         S_SEL:
         begin
            if (sel_wr.we)
            begin
               hs = hit_slot(sel_wr.page);
               // All-pages code and unknown pages spoil the whole select
               if (!hs[3] || sel_wr.off >= pg_len(hs[2:0], `MPS_PCF_CUR))
                  bad_nxt = 1'b1;  // R15
               else
               begin
                  bidx = pg_base(hs[2:0]) + 7'(sel_wr.off);
                  pend_nxt[bidx*8 +: 8] = (pend_r[bidx*8 +: 8] & ~CHG_MASK[bidx*8 +: 8])
                                        | (sel_wr.data & CHG_MASK[bidx*8 +: 8]);
               end
            end
            if (sel_done)
            begin
               chk_nxt = !(sel_ok && !bad_r);
               if (sel_ok && !bad_r)
                  cur_nxt = pend_r;  // R8 R3
               st_nxt = S_STAT;
            end
         end
         S_FMT:
            if (fmt_done)
            begin
               if (fmt_ok)
                  sav_nxt = cur_r;  // R9 R10
               chk_nxt = !fmt_ok;
               st_nxt = S_STAT;
            end
         S_SPIN:
            if (sd2_r && !sd3_r)
               st_nxt = S_STAT;  // R19
         S_STAT: st_nxt = S_IDLE;
      endcase
      // Output byte staged for the state being entered
      bidx = pg_base(slot_nxt) + 7'(cnt_nxt);
      unique case (st_nxt)
         S_CODE: dat_nxt = {2'b00, pg_code(slot_nxt)};
         S_LEN: dat_nxt = {3'b000, pg_len(slot_nxt, pcf_nxt)};  // R5 R16
         S_BODY:
            unique case (pcf_nxt)
               `MPS_PCF_CUR: dat_nxt = cur_r[bidx*8 +: 8];  // R3
               `MPS_PCF_CHG: dat_nxt = CHG_MASK[bidx*8 +: 8];  // R2
               `MPS_PCF_DEF: dat_nxt = DEF_IMAGE[bidx*8 +: 8];  // R4
               default: dat_nxt = saved_view[bidx*8 +: 8];  // R6
            endcase
         default: dat_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         st_r <= S_IDLE;
         slot_r <= 3'd0;
         cnt_r <= 5'd0;
         all_r <= 1'b0;
         page_control_field_r <= `MPS_PCF_CUR;
         chk_r <= 1'b0;
         bad_r <= 1'b0;
         dat_r <= 8'h00;
         cur_r <= DEF_IMAGE;
         sav_r <= DEF_IMAGE;
         pend_r <= DEF_IMAGE;
         sstart_r <= 1'b0;
         sup_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         slot_r <= slot_nxt;
         cnt_r <= cnt_nxt;
         all_r <= all_nxt;
         page_control_field_r <= pcf_nxt;
         chk_r <= chk_nxt;
         bad_r <= bad_nxt;
         dat_r <= dat_nxt;
         cur_r <= cur_nxt;
         sav_r <= sav_nxt;
         pend_r <= pend_nxt;
         sstart_r <= sstart_nxt;
         sup_r <= sup_nxt;
      end
   end

   // Mechanism done level crosses in; edge taken after the second stage
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sd1_r <= 1'b0;
         sd2_r <= 1'b0;
         sd3_r <= 1'b0;
      end
      else
      begin
         sd1_r <= spin_done_pin;
         sd2_r <= sd1_r;
         sd3_r <= sd2_r;
      end
   end

   assign cmd_ready = st_r == S_IDLE;
   assign out_valid = st_r == S_CODE || st_r == S_LEN || st_r == S_BODY;
   assign out_data = dat_r;
   assign spin_start = sstart_r;
   assign spin_up = sup_r;
   assign stat = '{valid: st_r == S_STAT, check: chk_r};

   sequence spin_issue_s;
      cmd_valid && cmd_ready && command_descriptor_block.opc == `MPS_OP_SPIN;
   endsequence

   sequence sense_req_s;
      cmd_valid && cmd_ready && command_descriptor_block.opc == `MPS_OP_SENSE;
   endsequence

   select_commit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R8
      $changed(cur_r) |-> $past(st_r == S_SEL && sel_done && sel_ok && !bad_r))
      else $error("current values changed without a good select");

   saved_update_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R9
      $changed(sav_r) |-> $past(st_r == S_FMT && fmt_done && fmt_ok))
      else $error("saved values changed without a good format");

   format_good_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R10
      st_r == S_FMT && fmt_done && fmt_ok |=> stat.valid && !stat.check && sav_r == $past(cur_r))
      else $error("good format did not store and report good");

   early_status_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R18
      spin_issue_s ##0 command_descriptor_block.b1[0] |=> spin_start && stat.valid)
      else $error("early status not given with spin start");

   late_status_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R19
      spin_issue_s ##0 !command_descriptor_block.b1[0] |=> spin_start && st_r == S_SPIN && !stat.valid)
      else $error("status given before spin completion");

   spin_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R19
      stat.valid && $past(st_r == S_SPIN) |-> $past(sd2_r && !sd3_r))
      else $error("spin wait left without a completion edge");

   spin_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R20
      spin_issue_s |=> spin_up == $past(command_descriptor_block.b4[0]))
      else $error("spin direction does not follow start bit");

   reserved_page_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R22
      sense_req_s ##0 hit_slot(command_descriptor_block.b2[5:0]) == 4'h0
      ##0 command_descriptor_block.b2[5:0] != `MPS_PC_ALL |=> stat.valid && !stat.check && !out_valid)
      else $error("reserved page not answered with plain good status");

   chg_format_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R12
      sense_req_s ##0 command_descriptor_block.b2 == {`MPS_PCF_CHG, `MPS_PG_FMT} |=> stat.valid && !out_valid)
      else $error("changeable format page returned bytes");

   page_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // R16
      out_valid && st_r == S_LEN |-> out_data == {3'b000, pg_len(slot_r, page_control_field_r)})
      else $error("length byte differs from page table");
endmodule : mps_top

/* File: verif/mps_init_model.sv */
// Initiator-side model: byte sink with periodic stalls, plus the spindle mechanism.
// Assumes clk_sys from the bench; spin completion arrives off the clock grid.
`timescale 1ns/1ps
module mps_init_model
   import mps_pkg::*;
#(
   parameter int SPIN_CYC = 24
)(
   input wire logic clk_sys,
   input wire logic spin_start,
   output logic out_ready,
   output logic spin_done_pin
);
   int n = 0;
   initial
   begin
      out_ready = 1'b0;
      spin_done_pin = 1'b0;
   end
   // Stall one cycle in three so held data gets exercised
   always @(posedge clk_sys)
   begin
      n <= n + 1;
      out_ready <= #1 (n % 3 != 2);
   end
   // Off-grid edge to exercise the synchroniser
   always @(posedge clk_sys)
   begin
      if (spin_start === 1'b1)
      begin
         repeat (SPIN_CYC) @(posedge clk_sys);
         #13 spin_done_pin = 1'b1;
         repeat (6) @(posedge clk_sys);
         spin_done_pin = 1'b0;
      end
   end
endmodule : mps_init_model

/* File: verif/testbench.sv */
// Self-checking bench: page reports, select/format storage, spindle start/stop.
// Assumes default image all zero and every bit changeable.
`timescale 1ns/1ps
`include "mps_cfg.svh"
module testbench
   import mps_pkg::*;
;
   logic clk_sys, rst_n, cmd_valid, cmd_ready, sel_done, sel_ok, fmt_done, fmt_ok;
   logic save_capable, spin_done_pin, spin_start, spin_up, out_valid, out_ready, chk_st;
   logic [7:0] out_data;
   logic [7:0] q[$];
   mps_cdb_s cdb;
   mps_selwr_s sel_wr;
   mps_stat_s stat;
   int miscompares = 0;
   int checked = 0;
   int lat;
   mps_top DUT (.clk_sys, .rst_n, .cmd_valid, .command_descriptor_block(cdb), .cmd_ready, .sel_wr, .sel_done,
      .sel_ok, .fmt_done, .fmt_ok, .save_capable, .spin_done_pin, .spin_start, .spin_up, .out_valid,
      .out_data, .out_ready, .stat);
   mps_init_model P (.clk_sys, .spin_start, .out_ready, .spin_done_pin);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   task automatic send(input mps_cdb_s c);
      @(negedge clk_sys);
      check(cmd_ready, 1'b1, "ready for command");
      cdb = c;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      check(cmd_ready, 1'b0, "busy after command");
   endtask : send
   // Collects streamed bytes until status, bounded
   task automatic wait_stat();
      int n;
      q = {};
      for (n = 1; n < 400 && stat.valid !== 1'b1; n++)
      begin
         if (out_valid === 1'b1 && out_ready === 1'b1)
            q.push_back(out_data);
         @(negedge clk_sys);
      end
      lat = n;
      chk_st = stat.check;
      if (n >= 400)
      begin
         miscompares++;
         end_of_test();
      end
   endtask : wait_stat
   task automatic sense(input logic [1:0] page_control_field, input logic [5:0] pg);
      send({`MPS_OP_SENSE, 8'h00, page_control_field, pg, 24'h000000});
      wait_stat();
   endtask : sense
   function automatic int exp_len(input logic [7:0] pg, input logic [1:0] page_control_field);
      case (pg)
         8'h00: return 2;
         8'h01: return 6;
         8'h02: return 10;
         8'h03: return (page_control_field == 2'b01) ? 0 : 22;
         8'h04: return (page_control_field == 2'b01) ? 0 : 16;
         8'h20: return 24;
         default: return 0;
      endcase
   endfunction : exp_len
   task automatic page_lengths();
      logic [5:0] pages[8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h20, 6'h05, 6'h21};
      int l;
      for (int p = 0; p < 4; p++)
         foreach (pages[i])
         begin
            sense(p[1:0], pages[i]);
            l = exp_len({2'b00, pages[i]}, p[1:0]);
            check(q.size(), (l == 0) ? 0 : l + 2, "reply size");
            check(chk_st, 1'b0, "sense status");
            if (l > 0)
            begin
               check(q[0], {2'b00, pages[i]}, "page code");
               check(q[1], l, "page length");
               for (int b = 2; b < q.size(); b++)
                  check(q[b], (p == 1) ? 8'hFF : 8'h00, "body byte");
            end
         end
   endtask : page_lengths
   task automatic all_pages();
      int i;
      int body;
      for (int p = 0; p < 4; p++)
      begin
         sense(p[1:0], `MPS_PC_ALL);
         i = 0;
         body = 0;
         while (i + 1 < q.size())
         begin
            check(q[i + 1], exp_len(q[i], p[1:0]), "all-pages length");
            body += q[i + 1];
            i += q[i + 1] + 2;
         end
         check(body, (p == 1) ? 42 : 80, "all-pages body");
      end
   endtask : all_pages
   task automatic do_select(input logic [5:0] pg, input logic [4:0] off, input logic ok);
      send({`MPS_OP_SELECT, 40'h0});
      @(negedge clk_sys);
      sel_wr = {1'b1, pg, off, 8'h5A};
      @(negedge clk_sys);
      sel_wr.we = 1'b0;
      sel_done = 1'b1;
      sel_ok = ok;
      @(negedge clk_sys);
      sel_done = 1'b0;
      wait_stat();
   endtask : do_select
   task automatic do_format(input logic ok);
      send({`MPS_OP_FORMAT, 40'h0});
      @(negedge clk_sys);
      fmt_done = 1'b1;
      fmt_ok = ok;
      @(negedge clk_sys);
      fmt_done = 1'b0;
      wait_stat();
      check(chk_st, !ok, "format status");
   endtask : do_format
   task automatic expect_byte(input logic [1:0] page_control_field, input logic [7:0] exp);
      sense(page_control_field, 6'h01);
      check(q[4], exp, "page 1 byte 2");
   endtask : expect_byte
   task automatic select_format();
      do_select(6'h01, 5'd2, 1'b1);
      check(chk_st, 1'b0, "select status");
      expect_byte(2'b00, 8'h5A);
      expect_byte(2'b11, 8'h00);
      do_select(6'h3F, 5'd0, 1'b1);
      check(chk_st, 1'b1, "all-pages select");
      do_select(6'h01, 5'd6, 1'b1);
      check(chk_st, 1'b1, "offset past page");
      do_select(6'h01, 5'd3, 1'b0);
      check(chk_st, 1'b1, "failed transfer");
      sense(2'b00, 6'h01);
      check(q[5], 8'h00, "current untouched");
      do_format(1'b0);
      expect_byte(2'b11, 8'h00);
      do_format(1'b1);
      expect_byte(2'b11, 8'h5A);
      expect_byte(2'b10, 8'h00);
      save_capable = 1'b0;
      expect_byte(2'b11, 8'h00);
      save_capable = 1'b1;
      send({8'hFF, 40'h0});
      wait_stat();
      check(chk_st, 1'b1, "unknown opcode status");
      check(lat, 1, "unknown opcode latency");
   endtask : select_format
   task automatic spin_cmds();
      logic e;
      logic s;
      for (int k = 0; k < 4; k++)
      begin
         e = k[1];
         s = k[0];
         send({`MPS_OP_SPIN, 7'h00, e, 16'h0000, 7'h00, s, 8'h00});
         check(spin_start, 1'b1, "spin start pulse");
         wait_stat();
         check(spin_up, s, "spin direction");
         check(chk_st, 1'b0, "spin status");
         if (e)
            check(lat, 1, "early status");
         else
            check(lat > 24, 1'b1, "status after spin");
         repeat (40) @(negedge clk_sys);
      end
   endtask : spin_cmds
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial
   begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cdb = '0;
      sel_wr = '0;
      sel_done = 1'b0;
      sel_ok = 1'b0;
      fmt_done = 1'b0;
      fmt_ok = 1'b0;
      save_capable = 1'b1;
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      page_lengths();
      all_pages();
      select_format();
      spin_cmds();
      end_of_test();
   end
endmodule : testbench
